// ### inc/irs_defines.svh
// Constants for the interrupt and reset-status block
// Assumes inclusion by bare name from the design files
`ifndef IRS_DEFINES_SVH
`define IRS_DEFINES_SVH
`define IRS_ADDR_EDGE_CTRL 8'h0e
`define IRS_ADDR_STATUS 8'h0f
`define IRS_ADDR_MASK 8'h0f
`define IRS_BIT_TIMER 0
`define IRS_BIT_PORT 1
`define IRS_BIT_EXT 2
`define IRS_BIT_WDT_RUN 7
`define IRS_BIT_EXT_SEL 6
`define IRS_VEC_INT 10'h008
`define IRS_VEC_SOFT 10'h001
`define IRS_FLAGS_RST 3'h0
`define IRS_MASK_RST 3'h0
`define IRS_EDGE_CTRL_RST 8'h80
`define IRS_PORT_W 8
`endif

// ### inc/irs_pkg.sv
// Types for the interrupt and reset-status block
// Assumes the defines header is on the include path
package irs_pkg;
    // Kind of reset seen by the block
    typedef enum logic [1:0] {
        IRS_RST_POWER = 2'b00,
        IRS_RST_PIN = 2'b01,
        IRS_RST_WDT = 2'b10
    } irs_rst_e;
    // Instruction strobes from the core
    typedef struct packed {
        logic enable_interrupts_instr;
        logic disable_interrupts_instr;
        logic return_from_interrupt_instr;
        logic sleep;
        logic watchdog_clear_instr;
        logic soft_int;
        logic boundary;
    } irs_instr_s;
    // Register access from the core
    typedef struct packed {
        logic rd_status;
        logic wr_status;
        logic rd_ctrl;
        logic wr_ctrl;
        logic rd_mask;
        logic wr_mask;
        logic [7:0] wdata;
    } irs_reg_s;
endpackage

// ### hdl/irs_edge.sv
// Falling-edge detector for one request line
// Assumes the input is synchronous to clk
`timescale 1ns/10ps
module irs_edge (
    input wire logic clk,
    input wire logic rst,
    input wire logic din,
    output logic fall
);
    logic prev_q;
    // Remember last level, idle high
    always_ff @(posedge clk) begin
        if (rst) begin
            prev_q <= 1'b1;
        end else begin
            prev_q <= din;
        end
    end
    assign fall = prev_q & ~din;
endmodule

// ### hdl/irs_change.sv
// Port input change detector with a reference latched on port read
// Assumes the port read strobe marks software sampling the port
`timescale 1ns/10ps
module irs_change import irs_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] port_in,
    input wire logic [7:0] port_is_output,
    input wire logic ext_sel,
    input wire logic port_read,
    output logic change
);
    logic [7:0] ref_q;
    logic [7:0] excl;
    // Reference taken whenever software reads the port or a change is seen
    always_ff @(posedge clk) begin
        if (rst) begin
            ref_q <= 8'h00;
        end else if (port_read) begin
            ref_q <= port_in;
        end else if (change) begin
            ref_q <= port_in;
        end
    end
    // Outputs and the external-interrupt pin do not count
    assign excl = port_is_output | {7'h00, ext_sel};
    assign change = |((port_in ^ ref_q) & ~excl);
endmodule

// ### hdl/irs_top.sv
// Interrupt flags, mask, global enable, vectoring and T/P status
// Assumes the core gives one-cycle instruction strobes and reset cause
`timescale 1ns/10ps
`include "irs_defines.svh"
module irs_top import irs_pkg::*; (
    input wire logic clk,
    input wire logic rst,
    input wire irs_rst_e rst_cause,
    input wire irs_instr_s instr,
    input wire irs_reg_s regs,
    input wire logic port_read,
    input wire logic timer_overflow_n,
    input wire logic port_b_bit0_pin,
    input wire logic [7:0] port_in,
    input wire logic [7:0] port_is_output,
    output logic [7:0] rdata,
    output logic vector_req,
    output logic [9:0] vector_addr,
    output logic wake,
    output logic sleeping,
    output logic timeout_flag,
    output logic powerdown_flag,
    output logic watchdog_run_enable,
    output logic external_int_pin_select
);
    ////////////////////////////////////////////////////////////////////
    logic [2:0] flags_q;
    logic [2:0] mask_q;
    logic [7:0] ctrl_q;
    logic gie_q;
    logic sleep_q;
    logic t_q;
    logic p_q;
    logic timer_fall;
    logic pin_fall;
    logic change;
    logic [2:0] set_v;
    logic [7:0] rdata_d;
    logic pending;

    // Timer overflow edge
    irs_edge u_timer (
        .clk(clk),
        .rst(rst),
        .din(timer_overflow_n),
        .fall(timer_fall)
    );
    // External pin edge
    irs_edge u_pin (
        .clk(clk),
        .rst(rst),
        .din(port_b_bit0_pin),
        .fall(pin_fall)
    );
    // Port change detector, software re-reads port first
    irs_change u_chg (
        .clk(clk),
        .rst(rst),
        .port_in(port_in),
        .port_is_output(port_is_output),
        .ext_sel(ctrl_q[`IRS_BIT_EXT_SEL]),
        .port_read(port_read),
        .change(change)
    );

    ////////////////////////////////////////////////////////////////////
    // Flag set terms; port change needs its mask
    always_comb begin
        set_v = 3'h0;
        set_v[`IRS_BIT_TIMER] = timer_fall;
        set_v[`IRS_BIT_EXT] = pin_fall & ctrl_q[`IRS_BIT_EXT_SEL];
        set_v[`IRS_BIT_PORT] = change & mask_q[`IRS_BIT_PORT];
    end

    // Status flags; a set beats a write clear
    always_ff @(posedge clk) begin
        if (rst) begin
            flags_q <= `IRS_FLAGS_RST;
        end else if (regs.wr_status) begin
            flags_q <= regs.wdata[2:0] | set_v;
        end else begin
            flags_q <= flags_q | set_v;
        end
    end

    // Mask register, written by its own strobe
    always_ff @(posedge clk) begin
        if (rst) begin
            mask_q <= `IRS_MASK_RST;
        end else if (regs.wr_mask) begin
            mask_q <= regs.wdata[2:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Edge control; watchdog run re-armed after any wake
    always_ff @(posedge clk) begin
        if (rst) begin
            ctrl_q <= `IRS_EDGE_CTRL_RST;
        end else if (wake) begin
            ctrl_q[`IRS_BIT_WDT_RUN] <= 1'b1;
        end else if (regs.wr_ctrl) begin
            ctrl_q <= regs.wdata;
        end
    end

    // Global enable
    always_ff @(posedge clk) begin
        if (rst) begin
            gie_q <= 1'b0;
        end else if (instr.disable_interrupts_instr) begin
            gie_q <= 1'b0;
        end else if (instr.enable_interrupts_instr ||
                     instr.return_from_interrupt_instr) begin
            gie_q <= 1'b1;
        end else if (vector_req) begin
            gie_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sleep state; a port change wakes when masked in
    assign wake = sleep_q & change & mask_q[`IRS_BIT_PORT];

    always_ff @(posedge clk) begin
        if (rst) begin
            sleep_q <= 1'b0;
        end else if (instr.sleep) begin
            sleep_q <= 1'b1;
        end else if (wake) begin
            sleep_q <= 1'b0;
        end
    end

    // T and P status flags per event
    always_ff @(posedge clk) begin
        if (rst) begin
            unique case (rst_cause)
                IRS_RST_POWER: begin
                    t_q <= 1'b1;
                    p_q <= 1'b1;
                end
                IRS_RST_PIN: begin
                    if (sleep_q) begin
                        t_q <= 1'b1;
                        p_q <= 1'b0;
                    end // otherwise both kept
                end
                IRS_RST_WDT: begin
                    t_q <= 1'b0;
                    if (sleep_q) begin
                        p_q <= 1'b0;
                    end
                end
                default: begin
                    t_q <= 1'b1;
                    p_q <= 1'b1;
                end
            endcase
        end else if (wake) begin
            t_q <= 1'b1;
            p_q <= 1'b0;
        end else if (instr.watchdog_clear_instr) begin
            t_q <= 1'b1;
            p_q <= 1'b1;
        end else if (instr.sleep) begin
            t_q <= 1'b1;
            p_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Pending request and vectoring at instruction boundaries or on wake
    assign pending = |(flags_q & mask_q);

    always_comb begin
        vector_req = 1'b0;
        vector_addr = `IRS_VEC_INT;
        if (instr.soft_int && instr.boundary) begin
            vector_req = 1'b1;
            vector_addr = `IRS_VEC_SOFT;
        end else if (wake) begin
            vector_req = gie_q;
        end else if (instr.boundary && gie_q && pending) begin
            vector_req = 1'b1;
        end
    end

    // Read data, status reads masked
    always_comb begin
        rdata_d = 8'h00;
        if (regs.rd_status) begin
            rdata_d = {5'h00, flags_q & mask_q};
        end else if (regs.rd_ctrl) begin
            rdata_d = ctrl_q;
        end else if (regs.rd_mask) begin
            rdata_d = {5'h00, mask_q};
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= 8'h00;
        end else begin
            rdata <= rdata_d;
        end
    end

    assign sleeping = sleep_q;
    assign timeout_flag = t_q;
    assign powerdown_flag = p_q;
    assign watchdog_run_enable = ctrl_q[`IRS_BIT_WDT_RUN];
    assign external_int_pin_select = ctrl_q[`IRS_BIT_EXT_SEL];

    ////////////////////////////////////////////////////////////////////
    AST_POWER_TP: assert property (@(posedge clk)
        rst && rst_cause == IRS_RST_POWER |=> t_q && p_q)
        else $error("power reset did not set T and P");
    AST_WDT_T: assert property (@(posedge clk)
        rst && rst_cause == IRS_RST_WDT |=> !t_q)
        else $error("watchdog reset kept T");
    AST_PIN_RUN: assert property (@(posedge clk)
        rst && rst_cause == IRS_RST_PIN && !sleep_q
        |=> t_q == $past(t_q) && p_q == $past(p_q))
        else $error("pin reset changed T or P");
    AST_WAKE_TP: assert property (@(posedge clk) disable iff (rst)
        wake |=> t_q && !p_q)
        else $error("wake did not update T and P");
    AST_STATUS_RD: assert property (@(posedge clk) disable iff (rst)
        regs.rd_status |=> rdata[2:0] == $past(flags_q & mask_q))
        else $error("status read not masked");
    AST_TIMER_SET: assert property (@(posedge clk) disable iff (rst)
        timer_fall |=> flags_q[0])
        else $error("timer flag not set");
    AST_VEC: assert property (@(posedge clk) disable iff (rst)
        instr.boundary && gie_q && pending && !instr.soft_int && !wake
        |-> vector_req && vector_addr == 10'h008)
        else $error("missed interrupt vector");
    AST_SOFT: assert property (@(posedge clk) disable iff (rst)
        instr.soft_int && instr.boundary |-> vector_addr == 10'h001)
        else $error("soft interrupt wrong vector");
    AST_GIE: assert property (@(posedge clk) disable iff (rst)
        instr.return_from_interrupt_instr &&
        !instr.disable_interrupts_instr |=> gie_q)
        else $error("return did not enable");
    AST_WDT_WAKE: assert property (@(posedge clk) disable iff (rst)
        wake |=> watchdog_run_enable)
        else $error("watchdog not re-enabled");

    AST_MASK_WR: assert property (@(posedge clk) disable iff (rst)
        regs.wr_mask |=> mask_q == $past(regs.wdata[2:0]))
        else $error("mask write lost");
    AST_ENABLE: assert property (@(posedge clk) disable iff (rst)
        instr.enable_interrupts_instr && !instr.disable_interrupts_instr
        |=> gie_q)
        else $error("enable did not set global enable");
    AST_DISABLE: assert property (@(posedge clk) disable iff (rst)
        instr.disable_interrupts_instr |=> !gie_q)
        else $error("disable did not clear global enable");
    AST_PIN_SLEEP: assert property (@(posedge clk)
        rst && rst_cause == IRS_RST_PIN && sleep_q |=> t_q && !p_q)
        else $error("pin reset from sleep gave wrong T or P");
    AST_WDT_SLEEP: assert property (@(posedge clk)
        rst && rst_cause == IRS_RST_WDT && sleep_q |=> !t_q && !p_q)
        else $error("watchdog reset from sleep gave wrong T or P");
    AST_SLEEP_TP: assert property (@(posedge clk) disable iff (rst)
        instr.sleep && !instr.watchdog_clear_instr && !wake
        |=> t_q && !p_q && sleeping)
        else $error("sleep did not update T, P or state");
    AST_CLEAR_TP: assert property (@(posedge clk) disable iff (rst)
        instr.watchdog_clear_instr && !wake |=> t_q && p_q)
        else $error("watchdog clear did not set T and P");
    AST_EXT_SET: assert property (@(posedge clk) disable iff (rst)
        pin_fall && external_int_pin_select |=> flags_q[`IRS_BIT_EXT])
        else $error("pin flag not set");
    AST_WAKE_VEC: assert property (@(posedge clk) disable iff (rst)
        wake && !(instr.soft_int && instr.boundary)
        |-> vector_req == gie_q && vector_addr == 10'h008)
        else $error("wake vectoring wrong");
    AST_WAKE_RUN: assert property (@(posedge clk) disable iff (rst)
        wake && !instr.sleep |=> !sleeping)
        else $error("wake did not leave sleep");
    AST_NO_VEC: assert property (@(posedge clk) disable iff (rst)
        !gie_q && !instr.soft_int |-> !vector_req)
        else $error("vector without global enable");
endmodule

// ### bench/irs_core_model.sv
// Behavioural model of the core fetch logic facing the interrupt block
// Assumes vector_req and vector_addr settle before each rising edge
`timescale 1ns/10ps
module irs_core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic vector_req,
    input wire logic [9:0] vector_addr,
    output logic boundary,
    output logic [9:0] pc
);
    // Two clocks per instruction, so a boundary every other edge
    always_ff @(posedge clk) begin
        if (rst) begin
            boundary <= 1'b0;
        end else begin
            boundary <= ~boundary;
        end
    end
    // Redirect fetch on a vector, else step at each boundary
    always_ff @(posedge clk) begin
        if (rst) begin
            pc <= 10'h000;
        end else if (vector_req) begin
            pc <= vector_addr;
        end else if (boundary) begin
            pc <= pc + 10'h001;
        end
    end
endmodule

// ### bench/test_interrupt_and_reset_status.sv
// Self-checking bench for the interrupt and reset-status block
// Assumes the core model paces boundaries and takes vectors
`timescale 1ns/10ps
module test_interrupt_and_reset_status import irs_pkg::*; ();
    localparam int I_EN = 6;
    localparam int I_RET = 4;
    localparam int I_SLEEP = 3;
    localparam int I_WDCLR = 2;
    localparam int I_SOFT = 1;
    logic clk = 1'b0;
    logic rst = 1'b1;
    irs_rst_e rst_cause = IRS_RST_POWER;
    irs_instr_s cmd = '0;
    irs_reg_s regs = '0;
    logic port_read = 1'b0;
    logic tmr_n = 1'b1;
    logic pin = 1'b1;
    logic [7:0] port_in = 8'h00;
    logic [7:0] port_out = 8'h00;
    logic [7:0] rdata;
    logic [7:0] d;
    logic [9:0] vector_addr;
    logic [9:0] pc;
    logic vector_req, wake, sleeping, t_flag, p_flag, wdt_en, ext_sel;
    logic boundary;
    int mismatches = 0;
    int num_checks = 0;
    int cycles = 0;

    ////////////////////////////////////////////////////////////////////////
    // Clock and cycle ceiling
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            give_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Design and core model
    irs_top dut_u (.clk(clk), .rst(rst), .rst_cause(rst_cause),
        .instr(irs_instr_s'({cmd[6:1], boundary})), .regs(regs),
        .port_read(port_read), .timer_overflow_n(tmr_n),
        .port_b_bit0_pin(pin), .port_in(port_in),
        .port_is_output(port_out), .rdata(rdata),
        .vector_req(vector_req), .vector_addr(vector_addr), .wake(wake),
        .sleeping(sleeping), .timeout_flag(t_flag),
        .powerdown_flag(p_flag), .watchdog_run_enable(wdt_en),
        .external_int_pin_select(ext_sel));
    irs_core_model core_u (.clk(clk), .rst(rst), .vector_req(vector_req),
        .vector_addr(vector_addr), .boundary(boundary), .pc(pc));

    ////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic check(input string nm, input logic [9:0] seen,
                         input logic [9:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic do_reset(input irs_rst_e c);
        rst = 1'b1;
        rst_cause = c;
        @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
    endtask
    // Strobes and accesses leave one idle cycle behind them
    task automatic strobe(input int k);
        cmd = irs_instr_s'(7'h01 << k);
        @(negedge clk);
        cmd = '0;
        @(negedge clk);
    endtask
    // Select 0 status, 1 edge control, 2 mask
    task automatic rd(input int sel);
        regs.rd_status = (sel == 0);
        regs.rd_ctrl = (sel == 1);
        regs.rd_mask = (sel == 2);
        @(negedge clk);
        d = rdata;
        regs = '0;
        @(negedge clk);
    endtask
    task automatic wr(input int sel, input logic [7:0] v);
        regs.wdata = v;
        regs.wr_status = (sel == 0);
        regs.wr_ctrl = (sel == 1);
        regs.wr_mask = (sel == 2);
        @(negedge clk);
        regs = '0;
        @(negedge clk);
    endtask
    // Wait a few cycles for a vector to 008H and its fetch
    task automatic wait_vec();
        int n;
        n = 0;
        #1;
        while (vector_req !== 1'b1 && n < 4) begin
            @(negedge clk);
            n++;
        end
        check("vector_req", vector_req, 1'b1);
        check("vector_addr", vector_addr, 10'h008);
        @(negedge clk);
        check("fetch_pc", pc, 10'h008);
    endtask
    task automatic tp(input logic t, input logic p);
        check("timeout_flag", t_flag, t);
        check("powerdown_flag", p_flag, p);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic test_tp();
        tp(1'b1, 1'b1);
        do_reset(IRS_RST_WDT);
        tp(1'b0, 1'b1);
        do_reset(IRS_RST_PIN);
        tp(1'b0, 1'b1);
        strobe(I_SLEEP);
        check("sleeping", sleeping, 1'b1);
        tp(1'b1, 1'b0);
        do_reset(IRS_RST_WDT);
        tp(1'b0, 1'b0);
        strobe(I_WDCLR);
        tp(1'b1, 1'b1);
        strobe(I_SLEEP);
        do_reset(IRS_RST_PIN);
        tp(1'b1, 1'b0);
        $display("test_tp done");
    endtask
    task automatic test_ctrl();
        rd(1'b1);
        check("ctrl_top", d[7:6], 2'b10);
        wr(1'b1, 8'h40);
        check("wdt_run", wdt_en, 1'b0);
        check("ext_sel", ext_sel, 1'b1);
        strobe(I_SLEEP);
        do_reset(IRS_RST_PIN);
        check("wdt_run", wdt_en, 1'b1);
        check("ext_sel", ext_sel, 1'b0);
        $display("test_ctrl done");
    endtask
    task automatic test_flags();
        wr(1'b1, 8'h40);
        tmr_n = 1'b0;
        pin = 1'b0;
        @(negedge clk);
        rd(0);
        check("status", d[2:0], 3'h0);
        wr(2, 8'h05);
        rd(2);
        check("mask", d[2:0], 3'h5);
        rd(0);
        check("status", d[2:0], 3'h5);
        wr(0, 8'h00);
        rd(0);
        check("status", d[2:0], 3'h0);
        tmr_n = 1'b1;
        pin = 1'b1;
        @(negedge clk);
        $display("test_flags done");
    endtask
    task automatic test_vec();
        wr(2, 8'h01);
        strobe(I_EN);
        tmr_n = 1'b0;
        wait_vec();
        cmd = irs_instr_s'(7'h01 << I_RET);
        @(negedge clk);
        cmd = '0;
        wait_vec();
        wr(0, 8'h00);
        wr(2, 8'h00);
        tmr_n = 1'b1;
        @(negedge clk);
        $display("test_vec done");
    endtask
    task automatic test_port();
        wr(2, 8'h00);
        wr(1, 8'h00);
        port_read = 1'b1;
        @(negedge clk);
        port_read = 1'b0;
        strobe(I_SLEEP);
        port_in = 8'h02;
        #1;
        check("wake", wake, 1'b0);
        @(negedge clk);
        check("sleeping", sleeping, 1'b1);
        port_in = 8'h00;
        port_read = 1'b1;
        @(negedge clk);
        port_read = 1'b0;
        wr(2, 8'h02);
        port_in = 8'h02;
        #1;
        check("wake", wake, 1'b1);
        check("vector_req", vector_req, 1'b0);
        @(negedge clk);
        check("sleeping", sleeping, 1'b0);
        check("wdt_run", wdt_en, 1'b1);
        tp(1'b1, 1'b0);
        rd(0);
        check("status", d[2:0], 3'h2);
        wr(0, 8'h00);
        wr(1, 8'h40);
        port_out = 8'h04;
        strobe(I_SLEEP);
        port_in = 8'h07;
        #1;
        check("wake", wake, 1'b0);
        @(negedge clk);
        check("sleeping", sleeping, 1'b1);
        strobe(I_EN);
        port_in = 8'h05;
        wait_vec();
        port_in = 8'h00;
        port_out = 8'h00;
        do_reset(IRS_RST_PIN);
        $display("test_port done");
    endtask
    task automatic test_soft();
        strobe(I_EN);
        while (boundary !== 1'b1) begin
            @(negedge clk);
        end
        cmd = irs_instr_s'(7'h01 << I_SOFT);
        #5;
        check("vector_req", vector_req, 1'b1);
        check("vector_addr", vector_addr, 10'h001);
        @(negedge clk);
        cmd = '0;
        check("fetch_pc", pc, 10'h001);
        $display("test_soft done");
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        test_tp();
        test_ctrl();
        test_flags();
        test_vec();
        test_port();
        test_soft();
        give_verdict();
    end
endmodule
